// file: design/bus_number_pkg.sv
// constants for the bridge bus number and secondary latency dword
package bus_number_pkg;
    localparam logic [7:0] CFG_DWORD_OFFSET   = 8'h18;
    localparam int         UPSTREAM_LSB       = 0;
    localparam int         DOWNSTREAM_LSB     = 8;
    localparam int         HIGHEST_LSB        = 16;
    localparam int         LATENCY_LSB        = 24;
    localparam int         LATENCY_FIELD_LSB  = 3;
    localparam int         BYTE_W             = 8;
    localparam logic [7:0] BUS_ID_RESET       = 8'h00;
    localparam logic [7:0] LATENCY_RESET      = 8'h00;
    localparam logic [7:0] LATENCY_WRITE_MASK = 8'hF8;
    localparam logic [7:0] LATENCY_ZERO       = 8'h00;
    localparam logic [7:0] LATENCY_ONE        = 8'h01;

    // decision for a type 1 configuration access
    typedef enum logic [2:0] {
        ROUTE_IGNORE          = 3'h0,
        ROUTE_DOWN_TYPE0      = 3'h1,
        ROUTE_DOWN_SPECIAL    = 3'h2,
        ROUTE_DOWN_TYPE1      = 3'h3,
        ROUTE_UP_SPECIAL      = 3'h4,
        ROUTE_UP_UNCHANGED    = 3'h5
    } route_t;

    // secondary master states, gray along idle->run->expired
    typedef enum logic [1:0] {
        LAT_IDLE    = 2'b00,
        LAT_RUN     = 2'b01,
        LAT_EXPIRED = 2'b11
    } lat_state_t;
endpackage

// file: design/downstream_latency_timer.sv
// secondary master latency counter
`timescale 1ns/10ps
module downstream_latency_timer
    import bus_number_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // control
    input  wire logic [7:0] latency_i,
    input  wire logic       frame_start_i,
    input  wire logic       master_active_i,
    // status
    output logic            expired_o
);
    typedef struct packed {
        lat_state_t state;
        logic [7:0] count;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (!master_active_i) begin
            s_d.state = LAT_IDLE;
        end else if (frame_start_i) begin
            // restart at every new frame while the master is active
            s_d.count = latency_i;
            s_d.state = (latency_i == LATENCY_ZERO) ? LAT_EXPIRED : LAT_RUN;
        end else begin
            unique case (s_q.state)
                LAT_IDLE: begin
                    s_d.state = LAT_IDLE;
                end
                LAT_RUN: begin
                    // one decrement per pci clock from frame assertion
                    s_d.count = s_q.count - LATENCY_ONE;
                    if (s_q.count == LATENCY_ONE) begin
                        s_d.state = LAT_EXPIRED;
                    end
                end
                LAT_EXPIRED: begin
                    s_d.state = LAT_EXPIRED;
                end
                default: begin
                    s_d.state = LAT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '{state: LAT_IDLE, count: LATENCY_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign expired_o = (s_q.state == LAT_EXPIRED);
endmodule

// file: design/bridge_bus_number_latency_regs.sv
// bus number and secondary latency configuration dword of a pci bridge
`timescale 1ns/10ps

module bridge_bus_number_latency_regs
    import bus_number_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // configuration write/read port
    input  wire logic        cfg_write_i,
    input  wire logic        cfg_read_i,
    input  wire logic [7:0]  cfg_offset_i,
    input  wire logic [3:0]  primary_cmd_byte_enable_n_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic [31:0]      cfg_rdata_o,
    // primary side type 1 decode
    input  wire logic        pri_type1_valid_i,
    input  wire logic [7:0]  pri_type1_bus_i,
    input  wire logic        pri_special_i,
    output logic             pri_claim_o,
    output route_t           pri_route_o,
    // secondary side type 1 decode
    input  wire logic        sec_type1_valid_i,
    input  wire logic [7:0]  sec_type1_bus_i,
    input  wire logic        sec_special_i,
    output logic             sec_claim_o,
    output route_t           sec_route_o,
    // secondary master
    input  wire logic        sec_frame_start_i,
    input  wire logic        sec_master_active_i,
    input  wire logic        sec_grant_n_i,
    input  wire logic        sec_data_phase_done_i,
    input  wire logic        sec_mwi_i,
    output logic             sec_release_o,
    output logic             sec_timer_expired_o
);
    typedef struct packed {
        logic [7:0]  upstream_bus_id;
        logic [7:0]  downstream_bus_id;
        logic [7:0]  highest_downstream_bus_id;
        logic [7:0]  downstream_master_latency;
        logic [31:0] rdata;
        logic        pri_claim;
        route_t      pri_route;
        logic        sec_claim;
        route_t      sec_route;
        logic        release_bus;
        logic        expired;
    } regs_state_t;

    regs_state_t s_q;
    regs_state_t s_d;
    logic        timer_expired;
    logic        hit;

    downstream_latency_timer u_timer (
        .clk_i           (clk_i),
        .reset_n_i       (reset_n_i),
        .latency_i       (s_q.downstream_master_latency),
        .frame_start_i   (sec_frame_start_i),
        .master_active_i (sec_master_active_i),
        .expired_o       (timer_expired)
    );

    assign hit = (cfg_offset_i == CFG_DWORD_OFFSET);

    always_comb begin
        s_d = s_q;
        // byte enables are active low, one per lane
        if (cfg_write_i && hit) begin
            if (!primary_cmd_byte_enable_n_i[0]) begin
                s_d.upstream_bus_id = cfg_wdata_i[UPSTREAM_LSB +: BYTE_W];
            end
            if (!primary_cmd_byte_enable_n_i[1]) begin
                s_d.downstream_bus_id = cfg_wdata_i[DOWNSTREAM_LSB +: BYTE_W];
            end
            if (!primary_cmd_byte_enable_n_i[2]) begin
                s_d.highest_downstream_bus_id = cfg_wdata_i[HIGHEST_LSB +: BYTE_W];
            end
            if (!primary_cmd_byte_enable_n_i[3]) begin
                // low three bits forced zero: eight-clock granularity
                s_d.downstream_master_latency =
                    cfg_wdata_i[LATENCY_LSB +: BYTE_W] & LATENCY_WRITE_MASK;
            end
        end

        // read data of the selected dword, zero elsewhere
        s_d.rdata = '0;
        if (cfg_read_i && hit) begin
            s_d.rdata = {s_q.downstream_master_latency, s_q.highest_downstream_bus_id,
                         s_q.downstream_bus_id, s_q.upstream_bus_id};
        end

        // primary side: claim for downstream buses
        s_d.pri_claim = 1'b0;
        s_d.pri_route = ROUTE_IGNORE;
        if (pri_type1_valid_i) begin
            if (pri_type1_bus_i == s_q.downstream_bus_id) begin
                s_d.pri_claim = 1'b1;
                s_d.pri_route = pri_special_i ? ROUTE_DOWN_SPECIAL : ROUTE_DOWN_TYPE0;
            end else if (pri_type1_bus_i > s_q.downstream_bus_id &&
                         pri_type1_bus_i <= s_q.highest_downstream_bus_id) begin
                s_d.pri_claim = 1'b1;
                s_d.pri_route = ROUTE_DOWN_TYPE1;
            end
        end

        // secondary side: upstream special cycle or pass up
        s_d.sec_claim = 1'b0;
        s_d.sec_route = ROUTE_IGNORE;
        if (sec_type1_valid_i) begin
            if (sec_special_i && sec_type1_bus_i == s_q.upstream_bus_id) begin
                s_d.sec_claim = 1'b1;
                s_d.sec_route = ROUTE_UP_SPECIAL;
            end else if (sec_type1_bus_i < s_q.downstream_bus_id ||
                         sec_type1_bus_i > s_q.highest_downstream_bus_id) begin
                // buses behind the bridge stay on the secondary side
                s_d.sec_claim = 1'b1;
                s_d.sec_route = ROUTE_UP_UNCHANGED;
            end
        end

        // release only at a data boundary, never mid memory write and invalidate
        s_d.expired     = timer_expired;
        s_d.release_bus = sec_master_active_i && timer_expired && sec_grant_n_i &&
                          sec_data_phase_done_i && !sec_mwi_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '{upstream_bus_id:           BUS_ID_RESET,
                     downstream_bus_id:         BUS_ID_RESET,
                     highest_downstream_bus_id: BUS_ID_RESET,
                     downstream_master_latency: LATENCY_RESET,
                     rdata:                     '0,
                     pri_claim:                 1'b0,
                     pri_route:                 ROUTE_IGNORE,
                     sec_claim:                 1'b0,
                     sec_route:                 ROUTE_IGNORE,
                     release_bus:               1'b0,
                     expired:                   1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata_o         = s_q.rdata;
    assign pri_claim_o         = s_q.pri_claim;
    assign pri_route_o         = s_q.pri_route;
    assign sec_claim_o         = s_q.sec_claim;
    assign sec_route_o         = s_q.sec_route;
    assign sec_release_o       = s_q.release_bus;
    assign sec_timer_expired_o = s_q.expired;
endmodule

// file: sim/bridge_bus_number_latency_regs_sva.sv
// assertions for the bus number and latency dword
`timescale 1ns/10ps
module bus_number_checker
    import bus_number_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        cfg_write_i,
    input wire logic        cfg_read_i,
    input wire logic [7:0]  cfg_offset_i,
    input wire logic [3:0]  primary_cmd_byte_enable_n_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        pri_type1_valid_i,
    input wire logic        pri_special_i,
    input wire logic        pri_claim_o,
    input wire route_t      pri_route_o,
    input wire logic        sec_type1_valid_i,
    input wire logic        sec_special_i,
    input wire route_t      sec_route_o,
    input wire logic        sec_frame_start_i,
    input wire logic        sec_master_active_i,
    input wire logic        sec_grant_n_i,
    input wire logic        sec_data_phase_done_i,
    input wire logic        sec_mwi_i,
    input wire logic        sec_release_o,
    input wire logic        sec_timer_expired_o
);
    logic [7:0] lat_q;
    // shadow of the latency lane, needed to know which count a frame loads
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lat_q <= LATENCY_RESET;
        end else if (cfg_write_i && cfg_offset_i == CFG_DWORD_OFFSET &&
                     !primary_cmd_byte_enable_n_i[3]) begin
            lat_q <= cfg_wdata_i[LATENCY_LSB +: BYTE_W] & LATENCY_WRITE_MASK;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic fs = sec_frame_start_i && sec_master_active_i;
    chk_rdata_idle: assert property (!cfg_read_i |=> cfg_rdata_o == 32'h0)
        else $error("read data not zero without read");
    chk_low_bits_zero: assert property (cfg_read_i |=> cfg_rdata_o[26:24] == 3'h0)
        else $error("latency low bits not zero");
    chk_pri_quiet: assert property (!pri_type1_valid_i |=> !pri_claim_o && pri_route_o == ROUTE_IGNORE)
        else $error("primary claim without access");
    chk_pri_claim_route: assert property (pri_claim_o |-> pri_route_o != ROUTE_IGNORE)
        else $error("primary claim without route");
    chk_sec_special: assert property (sec_type1_valid_i && !sec_special_i |=> sec_route_o != ROUTE_UP_SPECIAL)
        else $error("secondary special route without special");
    chk_release_cause: assert property (sec_release_o |-> $past(sec_data_phase_done_i && sec_grant_n_i && !sec_mwi_i))
        else $error("release without cause");
    chk_count_not_early: assert property (fs && lat_q == 8'h08 ##1 sec_master_active_i[*6] |-> !sec_timer_expired_o)
        else $error("timer expired early");
    chk_zero_expiry: assert property (fs && lat_q == 8'h00 ##1 sec_master_active_i[*2] |-> ##[0:1] sec_timer_expired_o)
        else $error("zero count did not expire");
    chk_frame_restart: assert property (fs && lat_q != 8'h00 |-> ##2 !sec_timer_expired_o)
        else $error("new frame did not restart timer");
    cov_release: cover property (sec_release_o);
    cov_claim: cover property (pri_claim_o);
    cov_expired: cover property (sec_timer_expired_o);
endmodule

bind bridge_bus_number_latency_regs bus_number_checker u_bus_number_checker (.*);

// file: sim/cfg_host_model.sv
// configuration host model driving the register port
`timescale 1ns/10ps
module cfg_host_model (
    input  wire logic   clk_i,
    output logic        cfg_write_o,
    output logic        cfg_read_o,
    output logic [7:0]  cfg_offset_o,
    output logic [3:0]  be_n_o,
    output logic [31:0] wdata_o
);
    initial {cfg_write_o, cfg_read_o, cfg_offset_o, be_n_o, wdata_o} = '0;
    // one strobe per access, held over exactly one sampling edge
    task automatic access(input logic w, input logic [7:0] o, input logic [3:0] b,
                          input logic [31:0] d);
        @(posedge clk_i);
        cfg_write_o <= w;
        cfg_read_o <= !w;
        cfg_offset_o <= o;
        be_n_o <= b;
        wdata_o <= d;
        @(posedge clk_i);
        cfg_write_o <= 1'b0;
        cfg_read_o <= 1'b0;
        // stale data inverted so a late sample cannot match by chance
        wdata_o <= ~d;
    endtask
endmodule

// file: sim/tb_bridge_bus_number_latency_regs.sv
// bench for the bus number and latency dword
`timescale 1ns/10ps
module tb_bridge_bus_number_latency_regs;
    import bus_number_pkg::*;
    logic clk_i = 0, reset_n_i = 0, wr, rd, pv = 0, ps = 0, sv = 0, ss = 0, pc, sc, rel, tmo;
    logic fs = 0, ma = 0, gn = 0, dd = 0, mwi = 0;
    logic [7:0] off, bus = 0;
    logic [3:0] be;
    logic [31:0] wd, rdat;
    route_t pr, sr;
    int mismatches = 0, samples_checked = 0, n;
    typedef struct packed { logic [3:0] b; logic [31:0] d; logic [31:0] e; } cfg_row_t;
    typedef struct packed { logic s; logic [7:0] bus; logic sp; route_t r; } dec_row_t;
    cfg_row_t cr [6] = '{'{4'h0, 32'hFFFFFFFF, 32'hF8FFFFFF}, '{4'hE, 0, 32'hF8FFFF00},
        '{4'hD, 0, 32'hF8FF0000}, '{4'hB, 0, 32'hF8000000}, '{4'h7, 0, 0},
        '{4'h0, 32'h0F060501, 32'h08060501}};
    dec_row_t dr [8] = '{'{0, 5, 0, ROUTE_DOWN_TYPE0}, '{0, 5, 1, ROUTE_DOWN_SPECIAL},
        '{0, 6, 0, ROUTE_DOWN_TYPE1}, '{0, 7, 0, ROUTE_IGNORE}, '{0, 4, 0, ROUTE_IGNORE},
        '{1, 1, 1, ROUTE_UP_SPECIAL}, '{1, 9, 0, ROUTE_UP_UNCHANGED}, '{1, 6, 0, ROUTE_IGNORE}};
    always #5 clk_i = ~clk_i;
    cfg_host_model u_cfg_host_model (.clk_i, .cfg_write_o(wr), .cfg_read_o(rd),
        .cfg_offset_o(off), .be_n_o(be), .wdata_o(wd));
    bridge_bus_number_latency_regs u_bridge_bus_number_latency_regs (.clk_i, .reset_n_i,
        .cfg_write_i(wr), .cfg_read_i(rd), .cfg_offset_i(off), .primary_cmd_byte_enable_n_i(be),
        .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .pri_type1_valid_i(pv), .pri_type1_bus_i(bus),
        .pri_special_i(ps), .pri_claim_o(pc), .pri_route_o(pr), .sec_type1_valid_i(sv),
        .sec_type1_bus_i(bus), .sec_special_i(ss), .sec_claim_o(sc), .sec_route_o(sr),
        .sec_frame_start_i(fs), .sec_master_active_i(ma), .sec_grant_n_i(gn),
        .sec_data_phase_done_i(dd), .sec_mwi_i(mwi), .sec_release_o(rel),
        .sec_timer_expired_o(tmo));
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic rd32(input logic [7:0] o, input logic [31:0] e);
        u_cfg_host_model.access(1'b0, o, 4'hF, 32'h0);
        #1 chk(e, rdat);
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic frame_wait(input int lim);
        @(posedge clk_i) fs <= 1;
        @(posedge clk_i) fs <= 0;
        n = 0;
        while (tmo !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1;
        rd32(CFG_DWORD_OFFSET, 32'h0);
        for (int i = 0; i < 6; i++) begin
            // host sets all three ids before any forwarding is relied on
            u_cfg_host_model.access(1'b1, CFG_DWORD_OFFSET, cr[i].b, cr[i].d);
            rd32(CFG_DWORD_OFFSET, cr[i].e);
        end
        rd32(8'h1C, 32'h0);
        $display("register rows done");
        foreach (dr[i]) begin
            @(posedge clk_i) {pv, sv, bus, ps, ss} <= {!dr[i].s, dr[i].s, dr[i].bus, {2{dr[i].sp}}};
            @(posedge clk_i) {pv, sv} <= 2'b00;
            #1 chk(32'(dr[i].r), 32'(dr[i].s ? sr : pr));
            chk(32'(dr[i].r != ROUTE_IGNORE), 32'(dr[i].s ? sc : pc));
        end
        $display("decode rows done");
        @(posedge clk_i) {ma, gn} <= 2'b11;
        frame_wait(40);
        chk(1, 32'(n == 9 || n == 10));
        @(posedge clk_i) {dd, mwi} <= 2'b11;
        @(posedge clk_i) dd <= 0;
        #1 chk(0, rel);
        @(posedge clk_i) {dd, mwi} <= 2'b10;
        @(posedge clk_i) dd <= 0;
        #1 chk(1, rel);
        @(posedge clk_i) fs <= 1;
        @(posedge clk_i) fs <= 0;
        @(posedge clk_i) #1 chk(0, tmo);
        u_cfg_host_model.access(1'b1, CFG_DWORD_OFFSET, 4'h7, 32'h0);
        frame_wait(5);
        chk(1, 32'(n <= 2));
        @(posedge clk_i) ma <= 0;
        $display("latency test done");
        // mid-run reset must clear the fields and the expired timer
        @(posedge clk_i) reset_n_i <= 0;
        repeat (2) @(posedge clk_i);
        #1 chk(0, tmo);
        chk(0, rdat);
        @(posedge clk_i) reset_n_i <= 1;
        rd32(CFG_DWORD_OFFSET, 32'h0);
        $display("reset test done");
        give_verdict();
    end
    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end
endmodule
